// ### gppm_board.sv
// Board model: pad levels seen by the port
module gppm_board (
  input  wire logic        rst_b,
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] drive,
  output logic      [15:0] pad
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb begin
    pad = (pin_oe & pin_out) | (~pin_oe & drive);
    if (!rst_b) pad[0] = 1'b0;
  end
endmodule : gppm_board

// ### gppm_chk.sv
// Port checker for the pin multiplexer
module gppm_chk
  import gppm_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  wb_adr_i,
  input wire logic        wb_we_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        single_bit_dac_output,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe
);
  logic wrote;
  logic next_wrote;
  always_comb begin
    next_wrote = wrote | (wb_ack_o & wb_we_i);
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) wrote <= 1'b0;
    else wrote <= next_wrote;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A pin whose output enable drops mid-wave stops being judged
  sequence s_div4;
    (pin_out[1] | !pin_oe[1])[*2] ##1 (!pin_out[1] | !pin_oe[1])[*2];
  endsequence
  sequence s_div6;
    (pin_out[2] | !pin_oe[2])[*3] ##1 (!pin_out[2] | !pin_oe[2])[*3];
  endsequence
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_div_four: assert property ($rose(pin_out[1]) && pin_oe[1] |-> s_div4)
    else $error("pin 1 clock not divided by four");
  a_div_six: assert property ($rose(pin_out[2]) && pin_oe[2] |-> s_div6)
    else $error("pin 2 clock not divided by six");
  a_dac_follow: assert property (pin_oe[8] |-> pin_out[8] == $past(single_bit_dac_output))
    else $error("pin 8 does not follow dac bit");
  a_stay_idle: assert property (!wrote |-> (pin_oe & 16'hfef9) == 16'h0)
    else $error("pin driven before configuration");
  a_dflt_drive: assert property ($past(rst_b) && !wrote |-> (pin_oe & 16'h0106) == 16'h0106)
    else $error("default outputs not driven");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > ADDR_GP0_INT
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule : gppm_chk
bind gppm_top gppm_chk u_chk (.clk, .rst_b, .wb_adr_i, .wb_we_i, .wb_stb_i, .wb_cyc_i,
  .wb_ack_o, .wb_dat_o, .single_bit_dac_output, .pin_out, .pin_oe);

// ### gppm_pkg.sv
// Constants for the general port pin multiplexer
package gppm_pkg;
  localparam int unsigned PORT_WIDTH = 16;
  localparam logic [7:0] ADDR_FUNC    = 8'h00;
  localparam logic [7:0] ADDR_DIR     = 8'h04;
  localparam logic [7:0] ADDR_OUT     = 8'h08;
  localparam logic [7:0] ADDR_IN      = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_POL = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_MASK    = 8'h1c;
  localparam logic [7:0] ADDR_GP0_INT = 8'h20;
  // Function select fields in the function register
  localparam int unsigned FUNC_GP0_LSB = 0;
  localparam int unsigned FUNC_PIN1    = 2;
  localparam int unsigned FUNC_PIN2    = 3;
  localparam int unsigned FUNC_PIN8    = 4;
  localparam int unsigned FUNC_HIGH    = 5;
  localparam logic [1:0] GP0_INPUT   = 2'h0;
  localparam logic [1:0] GP0_OUTPUT  = 2'h1;
  localparam logic [1:0] GP0_IRQ_OUT = 2'h2;
  localparam logic [5:0] FUNC_RESET  = 6'h00;
  localparam int unsigned EXT_LSB = 4;
  localparam int unsigned EXT_NUM = 4;
  localparam int unsigned DIV_SIX  = 6;
  localparam int unsigned DIV_FOUR = 4;
endpackage : gppm_pkg

// ### gppm_top.sv
// Pin function multiplexer for the sixteen-bit general port
// Function
// - Pins 15 to 9 have no function after reset until software enables them.
// - Pin 0 defaults to GPIO input; software may make it GPIO output.
// - Pin 0 may instead drive the general-purpose interrupt signal outward.
// - Pin 8 defaults to the DAC bit output; selectable as GPIO 8.
// - Pin 2 defaults to clock divided by six; selectable as GPIO 2.
// - Pin 1 defaults to clock divided by four; selectable as GPIO 1.
// - Pins 7 to 4 come out of reset as GPIO inputs.
// - Enabled pins 7 to 4 are edge interrupts; polarity bits pick the edge.
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
module gppm_top
  import gppm_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  input  wire logic                      wb_we_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_cyc_i,
  output logic                           wb_ack_o,
  input  wire logic                      single_bit_dac_output,
  input  wire logic [gppm_pkg::PORT_WIDTH-1:0] pin_in,
  output logic      [gppm_pkg::PORT_WIDTH-1:0] pin_out,
  output logic      [gppm_pkg::PORT_WIDTH-1:0] pin_oe,
  output logic                           irq
);
  import gppm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [5:0]            func;
  logic [15:0]           dir;
  logic [15:0]           dout;
  logic [3:0]            irq_en;
  logic [3:0]            irq_pol;
  logic [3:0]            status;
  logic [3:0]            mask;
  logic                  gp_int;
  logic [15:0]           sync_a;
  logic [15:0]           sync_b;
  logic [15:0]           sync_c;
  logic [2:0]            cnt_six;
  logic [1:0]            cnt_four;
  logic                  clk_six;
  logic                  clk_four;
  logic [5:0]            next_func;
  logic [15:0]           next_dir;
  logic [15:0]           next_dout;
  logic [3:0]            next_irq_en;
  logic [3:0]            next_irq_pol;
  logic [3:0]            next_status;
  logic [3:0]            next_mask;
  logic                  next_gp_int;
  logic [31:0]           next_dat;
  logic                  next_ack;
  logic [2:0]            next_cnt_six;
  logic [1:0]            next_cnt_four;
  logic                  next_clk_six;
  logic                  next_clk_four;
  logic [15:0]           next_out;
  logic [15:0]           next_oe;
  logic                  next_irq;
  logic                  wr;
  logic [3:0]            edge_hit;
  logic [31:0]           wr_word;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  ////////////////////////////////////////////////////////////////////////////
  // Clock dividers: square waves at one sixth and one quarter of clk
  always_comb begin
    next_cnt_six  = (cnt_six == 3'(DIV_SIX - 1)) ? 3'h0 : cnt_six + 3'h1;
    next_clk_six  = (cnt_six < 3'(DIV_SIX / 2 - 1)) || (cnt_six == 3'(DIV_SIX - 1));
    next_cnt_four = cnt_four + 2'h1;
    next_clk_four = (cnt_four < 2'(DIV_FOUR / 2 - 1)) || (cnt_four == 2'(DIV_FOUR - 1));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detect on the synchronised external interrupt pins
  always_comb begin
    for (int i = 0; i < EXT_NUM; i++) begin
      // Polarity one picks the falling edge, zero the rising edge
      edge_hit[i] = irq_en[i] && (irq_pol[i]
                    ? (sync_c[EXT_LSB+i] && !sync_b[EXT_LSB+i])
                    : (!sync_c[EXT_LSB+i] && sync_b[EXT_LSB+i]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and bus answer
  always_comb begin
    // A write lands at the edge where the master samples ack high
    wr           = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    next_func    = func;
    next_dir     = dir;
    next_dout    = dout;
    next_irq_en  = irq_en;
    next_irq_pol = irq_pol;
    next_mask    = mask;
    next_gp_int  = gp_int;
    next_status  = status;
    // Read mux doubles as the old word for byte-lane merging on writes
    case (wb_adr_i)
      ADDR_FUNC:    next_dat = 32'(func);
      ADDR_DIR:     next_dat = 32'(dir);
      ADDR_OUT:     next_dat = 32'(dout);
      ADDR_IN:      next_dat = 32'(sync_b);
      ADDR_IRQ_EN:  next_dat = 32'(irq_en);
      ADDR_IRQ_POL: next_dat = 32'(irq_pol);
      ADDR_STATUS:  next_dat = 32'(status);
      ADDR_MASK:    next_dat = 32'(mask);
      ADDR_GP0_INT: next_dat = 32'(gp_int);
      default:      next_dat = 32'h0;
    endcase
    wr_word = lane_merge(next_dat, wb_dat_i, wb_sel_i);
    if (wr) begin
      case (wb_adr_i)
        ADDR_FUNC:    next_func    = wr_word[5:0];
        ADDR_DIR:     next_dir     = wr_word[15:0];
        ADDR_OUT:     next_dout    = wr_word[15:0];
        ADDR_IRQ_EN:  next_irq_en  = wr_word[3:0];
        ADDR_IRQ_POL: next_irq_pol = wr_word[3:0];
        ADDR_MASK:    next_mask    = wr_word[3:0];
        ADDR_GP0_INT: next_gp_int  = wr_word[0];
        ADDR_STATUS:  next_status  = status & ~(wb_sel_i[0] ? wb_dat_i[3:0] : 4'h0);
        default:      next_func    = func;
      endcase
    end
    // A new edge wins over a clear in the same cycle
    next_status = next_status | edge_hit;
    next_ack    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_irq = |(next_status & next_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin function multiplexing
  always_comb begin
    next_out = dout;
    next_oe  = 16'h0000;
    // Pins 15 to 9 stay floating until their enable bit is set
    for (int i = 9; i < 16; i++) begin
      next_oe[i] = func[FUNC_HIGH] && dir[i];
    end
    // Pins 7 to 3 are direction-controlled; reset direction is input
    next_oe[3] = dir[3];
    for (int i = 0; i < EXT_NUM; i++) begin
      // A pin claimed as an interrupt input is never driven
      next_oe[EXT_LSB+i] = dir[EXT_LSB+i] && !irq_en[i];
    end
    case (func[FUNC_GP0_LSB +: 2])
      GP0_OUTPUT:  begin
        next_oe[0] = 1'b1;
      end
      GP0_IRQ_OUT: begin
        next_oe[0]  = 1'b1;
        next_out[0] = gp_int;
      end
      default:     begin
        next_oe[0] = 1'b0;
      end
    endcase
    if (func[FUNC_PIN1]) begin
      next_oe[1] = dir[1];
    end else begin
      next_oe[1]  = 1'b1;
      next_out[1] = clk_four;
    end
    if (func[FUNC_PIN2]) begin
      next_oe[2] = dir[2];
    end else begin
      next_oe[2]  = 1'b1;
      next_out[2] = clk_six;
    end
    if (func[FUNC_PIN8]) begin
      next_oe[8] = dir[8];
    end else begin
      next_oe[8]  = 1'b1;
      next_out[8] = single_bit_dac_output;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      func     <= FUNC_RESET;
      dir      <= 16'h0000;
      dout     <= 16'h0000;
      irq_en   <= 4'h0;
      irq_pol  <= 4'h0;
      status   <= 4'h0;
      mask     <= 4'h0;
      gp_int   <= 1'b0;
      sync_a   <= 16'h0000;
      sync_b   <= 16'h0000;
      sync_c   <= 16'h0000;
      cnt_six  <= 3'h0;
      cnt_four <= 2'h0;
      // Start high so the first half period after reset is full length
      clk_six  <= 1'b1;
      clk_four <= 1'b1;
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
      pin_out  <= 16'h0000;
      pin_oe   <= 16'h0000;
      irq      <= 1'b0;
    end else begin
      func     <= next_func;
      dir      <= next_dir;
      dout     <= next_dout;
      irq_en   <= next_irq_en;
      irq_pol  <= next_irq_pol;
      status   <= next_status;
      mask     <= next_mask;
      gp_int   <= next_gp_int;
      sync_a   <= pin_in;
      sync_b   <= sync_a;
      sync_c   <= sync_b;
      cnt_six  <= next_cnt_six;
      cnt_four <= next_cnt_four;
      clk_six  <= next_clk_six;
      clk_four <= next_clk_four;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
      pin_out  <= next_out;
      pin_oe   <= next_oe;
      irq      <= next_irq;
    end
  end
endmodule : gppm_top

// ### test_general_port_pin_mux.sv
// Self-checking bench for the pin multiplexer
module test_general_port_pin_mux
  import gppm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, we, stb, cyc, ack, dac, irq, g, pol;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0]  sel;
  logic [15:0] pin_in, pout, poe, drive, r, o, eo, mk;
  logic [5:0]  f;
  int          miscompares, checks_done;
  gppm_top dut (.clk, .rst_b, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we),
    .wb_sel_i(sel), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(ack),
    .single_bit_dac_output(dac), .pin_in, .pin_out(pout), .pin_oe(poe), .irq);
  gppm_board u_board (.rst_b, .pin_out(pout), .pin_oe(poe), .drive, .pad(pin_in));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) dac <= 1'($urandom);
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_oe(logic [5:0] fn);
    exp_oe = r & (fn[5] ? 16'hfe08 : 16'h0008);
    exp_oe[0] = fn[1:0] != GP0_INPUT;
    exp_oe[1] = ~fn[2];
    exp_oe[2] = ~fn[3];
    exp_oe[8] = ~fn[4];
  endfunction : exp_oe
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : check
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    check("ack", {31'h0, ack}, 32'h1);
  endtask : wb
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    check("oe dflt", 32'(poe), 32'h0106);
  endtask : do_reset
  task automatic final_report();
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial begin
    void'($urandom(32'h2e4c));
    {rst_b, cyc, stb, we} = 4'h0;
    {adr, wdat, sel} = {8'h0, 32'h0, 4'hf};
    drive = 16'($urandom);
    r = 16'($urandom) & 16'hfe09;
    o = 16'($urandom);
    g = 1'($urandom);
    do_reset();
    wb(8'h40, 1'b1, $urandom);
    wb(8'h40, 1'b0, 32'h0);
    check("unmapped", q, 32'h0);
    wb(ADDR_DIR, 1'b1, 32'(r));
    wb(ADDR_OUT, 1'b1, 32'(o));
    wb(ADDR_GP0_INT, 1'b1, 32'(g));
    for (int i = 0; i < 4; i++) begin
      f = (i == 0) ? 6'h00 : 6'(6'h3b + i);
      wb(ADDR_FUNC, 1'b1, 32'(f));
      repeat (4) @(posedge clk);
      eo = o;
      eo[0] = (f[1:0] == GP0_OUTPUT) ? o[0] : g;
      // Pins still carrying a clock or the DAC bit are left out of the compare
      mk = {7'h7f, f[4], 4'hf, 1'b1, f[3], f[2], 1'b1};
      check("oe", 32'(poe), 32'(exp_oe(f)));
      check("out", 32'(pout & poe & 16'hfef9), 32'(exp_oe(f) & eo & 16'hfef9));
      wb(ADDR_IN, 1'b0, 32'h0);
      check("in", 32'(q[15:0] & mk), 32'(((exp_oe(f) & eo) | (~exp_oe(f) & drive)) & mk));
    end
    wb(ADDR_IRQ_EN, 1'b1, 32'hf);
    wb(ADDR_MASK, 1'b1, 32'h7);
    for (int i = 0; i < 4; i++) begin
      pol = 1'($urandom);
      wb(ADDR_IRQ_POL, 1'b1, 32'(pol) << i);
      drive[4 + i] <= pol;
      repeat (8) @(posedge clk);
      wb(ADDR_STATUS, 1'b1, 32'hff);
      drive[4 + i] <= ~pol;
      repeat (8) @(posedge clk);
      wb(ADDR_STATUS, 1'b0, 32'h0);
      check("status", q & 32'hf, 32'h1 << i);
      check("irq", 32'(irq), 32'(i != 3));
      wb(ADDR_STATUS, 1'b1, 32'hff);
      repeat (2) @(posedge clk);
      check("irq clr", 32'(irq), 32'h0);
    end
    do_reset();
    final_report();
  end
endmodule : test_general_port_pin_mux
